/* File: design/acr_pkg.sv */
package acr_pkg;
  // ---------------------------------------------
  // Register map
  // ---------------------------------------------
  localparam logic [7:0] ACR_OFF_CSR = 8'h00;
  localparam logic [7:0] ACR_OFF_HIGH = 8'h04;
  localparam logic [7:0] ACR_OFF_LOW = 8'h08;
  localparam logic [7:0] ACR_OFF_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ACR_OFF_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] ACR_OFF_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] ACR_RESET_BYTE = 8'h00;
  localparam logic [9:0] ACR_RESULT_RESET = 10'h000;
  localparam int ACR_BIT_DONE = 7;
  localparam int ACR_BIT_FAST = 6;
  localparam int ACR_BIT_ON = 5;
  localparam int ACR_BIT_SLOW = 4;
  localparam int ACR_SEL_MSB = 3;
  // ---------------------------------------------
  // Conversion timing
  // ---------------------------------------------
  localparam int ACR_CLK_HZ = 20000000;
  localparam int ACR_FAST_MAX_HZ = 4000000;
  localparam logic [3:0] ACR_CONV_TICKS = 4'hb;
  localparam logic [1:0] ACR_DIV_ONE = 2'h0;
  localparam logic [1:0] ACR_DIV_TWO = 2'h1;
  localparam logic [1:0] ACR_DIV_FOUR = 2'h3;
  typedef struct packed {
    logic fast_select;
    logic converter_on;
    logic slow_select;
    logic [3:0] input_select_field;
  } acr_ctrl_t;
  typedef struct packed {
    logic start;
    logic [3:0] channel;
  } acr_conv_req_t;
  typedef struct packed {
    logic done;
    logic [9:0] value;
  } acr_conv_res_t;
endpackage

/* File: design/acr_clk_div.sv */
`timescale 1ns/1ns
module acr_clk_div (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic fast_i,
  input wire logic slow_i,
  output logic tick_o
);
  import acr_pkg::*;
  logic [1:0] cnt_q, cnt_d;
  logic [1:0] lim;
  logic tick_d;
  // ---------------------------------------------
  // Divider select
  // ---------------------------------------------
  always_comb begin
    if (slow_i && !fast_i) begin
      lim = ACR_DIV_FOUR;
    end else if (fast_i && !slow_i) begin
      lim = ACR_DIV_ONE;
    end else begin
      lim = ACR_DIV_TWO;
    end
    tick_d = 1'b0;
    cnt_d = cnt_q;
    if (!run_i) begin
      cnt_d = 2'h0;
    end else if (cnt_q >= lim) begin
      cnt_d = 2'h0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 2'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= 2'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule

/* File: design/acr_core_seq.sv */
`timescale 1ns/1ns
module acr_core_seq (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input acr_pkg::acr_conv_req_t req_i,
  input wire logic [9:0] sample_i,
  output acr_pkg::acr_conv_res_t res_o
);
  import acr_pkg::*;
  logic [3:0] cnt_q, cnt_d;
  acr_conv_res_t res_d;
  // ---------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    res_d = res_o;
    res_d.done = 1'b0;
    if (!req_i.start) begin
      cnt_d = 4'h0;
    end else if (tick_i) begin
      if (cnt_q == ACR_CONV_TICKS) begin
        cnt_d = 4'h0;
        res_d.done = 1'b1;
        res_d.value = sample_i;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= 4'h0;
      res_o <= '0;
    end else begin
      cnt_q <= cnt_d;
      res_o <= res_d;
    end
  end
endmodule

/* File: design/acr_top.sv */
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
module acr_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [9:0] sample_i,
  output logic [3:0] channel_o,
  output logic power_o,
  output logic irq_o
);
  import acr_pkg::*;
  // ---------------------------------------------
  // State and next values
  // ---------------------------------------------
  acr_ctrl_t ctrl_q, ctrl_d;
  logic done_q, done_d;
  logic [9:0] res_q, res_d;
  logic irq_st_q, irq_st_d;
  logic irq_en_q, irq_en_d;
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic [3:0] channel_d;
  logic power_d;
  logic irq_d;
  // ---------------------------------------------
  // Internal strobes
  // ---------------------------------------------
  logic tick;
  acr_conv_req_t req;
  acr_conv_res_t conv;
  logic acc;
  logic first;
  logic wr;
  logic rd;
  logic wr_csr;
  logic rd_high;
  logic irq_en_wr;
  logic irq_clr;
  logic conv_end;
  // ---------------------------------------------
  // Map check
  // ---------------------------------------------
  // Address lies inside the register map
  function automatic logic is_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      ACR_OFF_CSR, ACR_OFF_HIGH, ACR_OFF_LOW: begin
        hit = 1'b1;
      end
      ACR_OFF_IRQ_STATUS, ACR_OFF_IRQ_ENABLE, ACR_OFF_IRQ_CLEAR: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction
  // ---------------------------------------------
  // Register select
  // ---------------------------------------------
  // Address names the given register
  function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
    logic same;
    same = (addr == off);
    return same;
  endfunction
  // ---------------------------------------------
  // Control readback
  // ---------------------------------------------
  // Image of the control/status register
  function automatic logic [31:0] csr_image(input acr_ctrl_t ctrl, input logic done);
    logic [31:0] word;
    word = 32'h0000_0000;
    word[ACR_BIT_DONE] = done;
    word[ACR_BIT_FAST] = ctrl.fast_select;
    word[ACR_BIT_ON] = ctrl.converter_on;
    word[ACR_BIT_SLOW] = ctrl.slow_select;
    word[ACR_SEL_MSB:0] = ctrl.input_select_field;
    return word;
  endfunction
  // ---------------------------------------------
  // Bus strobes
  // ---------------------------------------------
  // First access cycle prepares the answer; pready_o rises for the second
  assign acc = psel_i && penable_i;
  assign first = acc && !pready_o;
  // Writes and read side effects land only at the completing edge
  assign wr = acc && pready_o && pwrite_i;
  assign rd = acc && pready_o && !pwrite_i;
  assign wr_csr = wr && hits(paddr_i, ACR_OFF_CSR);
  assign rd_high = rd && hits(paddr_i, ACR_OFF_HIGH);
  assign irq_en_wr = wr && hits(paddr_i, ACR_OFF_IRQ_ENABLE);
  assign irq_clr = wr && hits(paddr_i, ACR_OFF_IRQ_CLEAR) && pwdata_i[0];
  assign conv_end = conv.done && ctrl_q.converter_on;
  assign req.start = ctrl_q.converter_on;
  assign req.channel = ctrl_q.input_select_field;
  // ---------------------------------------------
  // Submodules
  // ---------------------------------------------
  acr_clk_div u_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .run_i(ctrl_q.converter_on),
    .fast_i(ctrl_q.fast_select),
    .slow_i(ctrl_q.slow_select),
    .tick_o(tick)
  );
  acr_core_seq u_seq (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_i(tick),
    .req_i(req),
    .sample_i(sample_i),
    .res_o(conv)
  );
  // ---------------------------------------------
  // Control register
  // ---------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_csr) begin
      ctrl_d.fast_select = pwdata_i[ACR_BIT_FAST];
      ctrl_d.converter_on = pwdata_i[ACR_BIT_ON];
      ctrl_d.slow_select = pwdata_i[ACR_BIT_SLOW];
      ctrl_d.input_select_field = pwdata_i[ACR_SEL_MSB:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end
  // ---------------------------------------------
  // Conversion-done flag
  // ---------------------------------------------
  always_comb begin
    done_d = done_q;
    if (wr_csr || rd_high) begin
      done_d = 1'b0;
    end
    // A finishing conversion wins over a clear in the same cycle
    if (conv_end) begin
      done_d = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end
  // ---------------------------------------------
  // Result registers
  // ---------------------------------------------
  always_comb begin
    res_d = res_q;
    // Loaded in the same cycle that sets the done flag
    if (conv_end) begin
      res_d = conv.value;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      res_q <= ACR_RESULT_RESET;
    end else begin
      res_q <= res_d;
    end
  end
  // ---------------------------------------------
  // Interrupt status
  // ---------------------------------------------
  always_comb begin
    irq_st_d = irq_st_q;
    if (irq_clr) begin
      irq_st_d = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (conv_end) begin
      irq_st_d = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_st_q <= 1'b0;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end
  // ---------------------------------------------
  // Interrupt enable
  // ---------------------------------------------
  always_comb begin
    irq_en_d = irq_en_q;
    if (irq_en_wr) begin
      irq_en_d = pwdata_i[0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_en_q <= 1'b0;
    end else begin
      irq_en_q <= irq_en_d;
    end
  end
  // ---------------------------------------------
  // Read data
  // ---------------------------------------------
  always_comb begin
    prdata_d = 32'h0000_0000;
    // Prepared in the first access cycle, stands in the second
    if (first && !pwrite_i) begin
      case (paddr_i)
        ACR_OFF_CSR: begin
          prdata_d = csr_image(ctrl_q, done_q);
        end
        ACR_OFF_HIGH: begin
          prdata_d[7:0] = res_q[9:2];
        end
        ACR_OFF_LOW: begin
          prdata_d[1:0] = res_q[1:0];
        end
        ACR_OFF_IRQ_STATUS: begin
          prdata_d[0] = irq_st_q;
        end
        ACR_OFF_IRQ_ENABLE: begin
          prdata_d[0] = irq_en_q;
        end
        default: begin
          prdata_d = 32'h0000_0000;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h0000_0000;
    end else begin
      prdata_o <= prdata_d;
    end
  end
  // ---------------------------------------------
  // Bus response
  // ---------------------------------------------
  always_comb begin
    pslverr_d = 1'b0;
    // One wait state: pready_o is high only in the second access cycle
    pready_d = first;
    if (first) begin
      pslverr_d = !is_mapped(paddr_i);
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= pready_d;
      pslverr_o <= pslverr_d;
    end
  end
  // ---------------------------------------------
  // Converter outputs and interrupt line
  // ---------------------------------------------
  always_comb begin
    channel_d = ctrl_d.input_select_field;
    power_d = ctrl_d.converter_on;
    irq_d = irq_st_d && irq_en_d;
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      channel_o <= 4'h0;
      power_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      channel_o <= channel_d;
      power_o <= power_d;
      irq_o <= irq_d;
    end
  end
endmodule

/* File: bench/acr_core_model.sv */
`timescale 1ns/1ns
module acr_core_model (
  input wire logic [3:0] channel_i,
  input wire logic power_i,
  output logic [9:0] sample_o
);
  logic [9:0] val;
  // Each input gives its own level
  assign val = {channel_i, 6'h2b ^ {2'h0, channel_i}};
  // Powered down core shows no valid level
  assign sample_o = power_i ? val : ~val;
endmodule

/* File: bench/acr_top_assertions.sv */
`timescale 1ns/1ns
module acr_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [3:0] channel_o,
  input wire logic power_o,
  input wire logic irq_o
);
  import acr_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic acc, wr_csr, rd_csr, rd_low;
  assign acc = psel_i && penable_i && pready_o;
  assign wr_csr = acc && pwrite_i && paddr_i == ACR_OFF_CSR;
  assign rd_csr = acc && !pwrite_i && paddr_i == ACR_OFF_CSR;
  assign rd_low = acc && !pwrite_i && paddr_i == ACR_OFF_LOW;
  a_reset_zero: assert property (!$past(rstn_i) |-> !power_o && channel_o == 4'h0)
    else $error("not cleared by reset");
  a_on_follow: assert property (wr_csr |=> power_o == $past(pwdata_i[ACR_BIT_ON]))
    else $error("power wrong");
  a_on_hold: assert property (!wr_csr |=> $stable(power_o))
    else $error("power moved");
  a_sel_follow: assert property (wr_csr |=> channel_o == $past(pwdata_i[3:0]))
    else $error("channel wrong");
  a_csr_view: assert property (rd_csr |-> prdata_o[5] == power_o && prdata_o[3:0] == channel_o)
    else $error("control readback wrong");
  a_low_zero: assert property (rd_low |-> prdata_o[31:2] == 30'h0)
    else $error("low upper bits set");
  a_irq_mask: assert property (acc && pwrite_i && paddr_i == ACR_OFF_IRQ_ENABLE && !pwdata_i[0]
    |-> ##2 !irq_o)
    else $error("masked interrupt high");
  a_bad_addr: assert property (acc && paddr_i > ACR_OFF_IRQ_CLEAR |-> ##[0:1] pslverr_o)
    else $error("no error on unmapped");
  c_on: cover property (wr_csr && pwdata_i[ACR_BIT_ON]);
  c_irq: cover property (irq_o);
  c_err: cover property (pslverr_o);
endmodule
bind acr_top acr_chk u_acr_chk (.*);

/* File: bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import acr_pkg::*;
  logic clk_i = 0, rstn_i = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd, v;
  logic prdy, perr, pwr_o, irq, er;
  logic [9:0] smp, e;
  logic [3:0] ch;
  logic [9:0] exp_q[$];
  logic [7:0] ad[3] = '{ACR_OFF_CSR, ACR_OFF_HIGH, ACR_OFF_LOW};
  int fail_count = 0, checks_done = 0, cyc = 0, t0, d;
  acr_top u_acr_top (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .sample_i(smp), .channel_o(ch), .power_o(pwr_o), .irq_o(irq));
  acr_core_model u_acr_core_model (.channel_i(ch), .power_i(pwr_o), .sample_o(smp));
  initial forever #25 clk_i = ~clk_i;
  task summarize;
    $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] dt);
    psel <= 1; pwr <= w; pa <= a; pwd <= dt; pen <= 0;
    @(posedge clk_i) pen <= 1;
    do @(posedge clk_i); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 0; pen <= 0;
    @(posedge clk_i);
  endtask
  task wait_done;
    rd = 0;
    for (int i = 0; i < 60 && rd[7] !== 1'b1; i++) xfer(0, ACR_OFF_CSR, 0);
  endtask
  initial begin
    v = $urandom(73);
    repeat (2) @(posedge clk_i);
    rstn_i <= 1;
    @(posedge clk_i);
    foreach (ad[i]) begin
      xfer(0, ad[i], 0);
      chk(rd, 0);
    end
    for (int k = 0; k < 8; k++) begin
      v = {25'h0, k[0], 1'b1, k[1], (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($urandom)};
      d = v[6] ? (v[4] ? 2 : 1) : (v[4] ? 4 : 2);
      exp_q.push_back({v[3:0], 6'h2b ^ {2'h0, v[3:0]}});
      xfer(1, ACR_OFF_CSR, 0);
      t0 = cyc;
      xfer(1, ACR_OFF_CSR, v | 32'h80);
      chk(32'(ch), v[3:0]);
      wait_done();
      chk(32'(cyc - t0 >= 11 * d && cyc - t0 <= 13 * d + 10), 1);
      chk(rd, v | 32'h80);
      e = exp_q.pop_front();
      xfer(0, ACR_OFF_HIGH, 0);
      chk(rd, {24'h0, e[9:2]});
      xfer(0, ACR_OFF_CSR, 0);
      chk(rd, v);
      xfer(0, ACR_OFF_LOW, 0);
      chk(rd, {30'h0, e[1:0]});
    end
    xfer(1, ACR_OFF_CSR, 0);
    xfer(1, ACR_OFF_IRQ_CLEAR, 1);
    xfer(1, ACR_OFF_IRQ_ENABLE, 1);
    chk(irq, 0);
    xfer(1, ACR_OFF_CSR, 32'h25);
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk_i);
    chk(irq, 1);
    xfer(1, ACR_OFF_CSR, 32'h05);
    xfer(0, ACR_OFF_CSR, 0);
    chk(rd, 32'h05);
    xfer(1, ACR_OFF_IRQ_CLEAR, 1);
    chk(irq, 0);
    repeat (80) @(posedge clk_i);
    xfer(0, ACR_OFF_CSR, 0);
    chk(rd, 32'h05);
    xfer(1, ACR_OFF_IRQ_ENABLE, 0);
    xfer(1, ACR_OFF_CSR, 32'h25);
    repeat (60) @(posedge clk_i);
    chk(irq, 0);
    xfer(0, ACR_OFF_IRQ_STATUS, 0);
    chk(rd[0], 1);
    xfer(0, 8'h18, 0);
    chk(er, 1);
    summarize();
  end
endmodule
